//--- hw/bdm_unit.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
module bdm_unit
  import bdm_pkg::*;
#(
  parameter int DEPTH = 64
)(
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,

  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [bdm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output      logic [31:0]                prdata,
  output      logic                       pready,
  output      logic                       pslverr,

  // result flags
  output      logic                       error_flag,
  output      logic                       greater_flag,
  output      logic                       equal_flag,
  output      logic                       less_flag,
  output      logic                       busy
);
  import bdm_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 4;
  localparam logic [20:0] BIT_LIM = 21'(DEPTH * 16);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_XFR  = 1'b1
  } bdm_state_type;

  // registers
  bdm_state_type   state_q, state_d;
  logic [4:0]      ctrl_q;
  logic [15:0]     src_q, sel_q, dst_q;
  logic [31:0]     addr_q;
  logic            go_q;
  logic            err_q, gt_q, eq_q, lt_q;
  logic [PW-1:0]   sp_q, dp_q;
  logic [7:0]      cnt_q;
  logic [31:0]     prdata_q;
  logic            pready_q, pslverr_q;
  logic            busy_w;

  // data memory, one data area
  logic [15:0]     mem [DEPTH];

  // apb decode
  logic            is_ctrl, is_src, is_sel, is_dst, is_addr, is_stat;
  logic            is_mem, mapped, refuse;
  logic [11:0]     mem_off;
  logic [AW-1:0]   mem_ai;
  logic            setup_wait, apb_acc, wr_ok;
  logic [31:0]     rd_word;
  logic [4:0]      stat_word;

  assign is_ctrl = paddr == OFS_CTRL;
  assign is_src  = paddr == OFS_SRC;
  assign is_sel  = paddr == OFS_SEL;
  assign is_dst  = paddr == OFS_DST;
  assign is_addr = paddr == OFS_ADDR;
  assign is_stat = paddr == OFS_STAT;
  assign mem_off = paddr - MEM_BASE;
  assign is_mem  = (paddr >= MEM_BASE) && (mem_off[1:0] == 2'b00) &&
                   (mem_off[11:2] < 10'(DEPTH));
  assign mem_ai  = mem_off[AW+1:2];
  assign mapped  = is_ctrl | is_src | is_sel | is_dst | is_addr |
                   is_stat | is_mem;

  // writes while an operation runs would race it, so refuse them
  assign refuse     = !mapped || (pwrite && (is_stat || busy_w));
  assign setup_wait = psel && penable && !pready_q;
  assign apb_acc    = psel && penable && pready_q;
  assign wr_ok      = apb_acc && pwrite && !pslverr_q;

  // one op at a time; bus refuses writes until it is done
  assign busy_w = go_q || (state_q != ST_IDLE);

  assign stat_word = {lt_q, eq_q, gt_q, err_q, busy_w};
  assign rd_word = is_ctrl ? {27'h0, ctrl_q} :
                   is_src  ? {16'h0, src_q} :
                   is_sel  ? {16'h0, sel_q} :
                   is_dst  ? {16'h0, dst_q} :
                   is_addr ? addr_q :
                   is_stat ? {27'h0, stat_word} :
                   is_mem  ? {16'h0, mem[mem_ai]} : 32'h0;

  // operand decode
  bdm_op_type      op;
  logic            cond;
  logic            ind;
  logic [13:0]     ptr_bin;
  logic            ptr_ok;
  logic            ind_err;
  logic [15:0]     base;
  logic [15:0]     dbase;

  assign op    = bdm_op_type'(ctrl_q[CTRL_OP_LSB +: 3]);
  assign ind   = ctrl_q[CTRL_IND];
  assign cond  = pwdata[CTRL_COND];
  assign dbase = addr_q[31:16];

  bdm_bcd_word u_ptr (
    .bcd   (addr_q[15:0]),
    .bin   (ptr_bin),
    .valid (ptr_ok)
  );

  // pointer must be bcd and inside the memory
  assign ind_err = ind && (!ptr_ok ||
                   ({2'b00, ptr_bin} >= 16'(DEPTH)));
  assign base = ind ? {2'b00, ptr_bin} : addr_q[15:0];

  // word operations
  bdm_word_if wif ();

  assign wif.op  = op;
  assign wif.src = src_q;
  assign wif.sel = sel_q;
  assign wif.dst = dst_q;

  bdm_word_ops u_ops (
    .w (wif.core)
  );

  // multi-bit transfer checks
  // a zero count is a legal no-op; only a bad indirect pointer sets error then
  logic [3:0]      x_sbit, x_dbit;
  logic [7:0]      x_cnt;
  logic [20:0]     src_last, dst_last;
  logic            xfr_err;

  assign x_sbit = sel_q[3:0];
  assign x_dbit = sel_q[7:4];
  assign x_cnt  = sel_q[15:8];
  assign src_last = {1'b0, base, 4'h0} + 21'(x_sbit) + 21'(x_cnt) - 21'd1;
  assign dst_last = {1'b0, dbase, 4'h0} + 21'(x_dbit) + 21'(x_cnt) -
                    21'd1;
  assign xfr_err = ind_err || ((x_cnt != 8'h00) &&
                   ((src_last >= BIT_LIM) ||
                    (dst_last >= BIT_LIM)));

  // table compare
  // tbl_err keeps the sixteen indices inside memory
  logic            tbl_err;
  logic [15:0]     tbl_hit;

  assign tbl_err = ind_err ||
                   (({1'b0, base} + 17'(TABLE_LEN - 1)) >=
                    17'(DEPTH));

  for (genvar i = 0; i < TABLE_LEN; i++) begin : g_tbl
    logic [AW-1:0] idx;
    assign idx = base[AW-1:0] + AW'(i);
    assign tbl_hit[i] = mem[idx] == src_q;
  end

  // bit-serial transfer datapath; bit 15 rolls into next word
  logic [AW-1:0]   sw, dw;
  logic            sbit;
  logic [15:0]     dword;

  assign sw   = sp_q[PW-1:4];
  assign dw   = dp_q[PW-1:4];
  assign sbit = mem[sw][sp_q[3:0]];

  always_comb begin
    dword = mem[dw];
    dword[dp_q[3:0]] = sbit;
  end

  // memory write port: transfer owns it while running
  logic            mem_we;
  logic [AW-1:0]   mem_wa;
  logic [15:0]     mem_wd;
  logic            xfr_run;

  assign xfr_run = state_q == ST_XFR;
  assign mem_we  = xfr_run || (wr_ok && is_mem);
  assign mem_wa  = xfr_run ? dw : mem_ai;
  assign mem_wd  = xfr_run ? dword : pwdata[15:0];

  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // execution control
  logic            op_go;
  logic            xfr_start;
  logic            xfr_last;

  assign op_go     = go_q;
  assign xfr_start = op_go && (op == OP_XFR) && !xfr_err &&
                     (x_cnt != 8'h00);
  assign xfr_last  = xfr_run && (cnt_q == 8'h01);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (xfr_start) begin
          state_d = ST_XFR;
        end
      end
      ST_XFR: begin
        if (xfr_last) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // apb response, one wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_wait;
      pslverr_q <= setup_wait && refuse;
      prdata_q  <= (setup_wait && !pwrite && !refuse) ? rd_word : 32'h0;
    end
  end

  // software registers; start only when condition bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      src_q  <= WORD_RST;
      sel_q  <= WORD_RST;
      addr_q <= ADDR_RST;
      go_q   <= 1'b0;
    end else begin
      go_q <= wr_ok && is_ctrl && cond;
      if (wr_ok && is_ctrl) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
      if (wr_ok && is_src) begin
        src_q <= pwdata[15:0];
      end
      if (wr_ok && is_sel) begin
        sel_q <= pwdata[15:0];
      end
      if (wr_ok && is_addr) begin
        addr_q <= pwdata;
      end
    end
  end

  // flags change only on a started operation; destination also on a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_q <= WORD_RST;
      err_q <= 1'b0;
      gt_q  <= 1'b0;
      eq_q  <= 1'b0;
      lt_q  <= 1'b0;
    end else if (op_go) begin
      unique case (op)
        OP_BIT, OP_NIB: begin
          err_q <= wif.err || ind_err;
          if (!wif.err && !ind_err) begin
            dst_q <= wif.res;
          end
        end
        OP_XFR: begin
          err_q <= xfr_err;
        end
        OP_CMP: begin
          // greater/equal/less flags move only on a clean compare
          err_q <= ind_err;
          if (!ind_err) begin
            gt_q <= wif.gt;
            eq_q <= wif.eq;
            lt_q <= wif.lt;
          end
        end
        OP_TBL: begin
          err_q <= tbl_err;
          if (!tbl_err) begin
            dst_q <= tbl_hit;
          end
        end
        default: begin
          // illegal opcode: error only, data untouched
          err_q <= 1'b1;
        end
      endcase
    end else if (wr_ok && is_dst) begin
      dst_q <= pwdata[15:0];
    end
  end

  // transfer pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      sp_q    <= '0;
      dp_q    <= '0;
      cnt_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      if (xfr_start) begin
        sp_q  <= {base[AW-1:0], x_sbit};
        dp_q  <= {dbase[AW-1:0], x_dbit};
        cnt_q <= x_cnt;
      end else if (xfr_run) begin
        sp_q  <= sp_q + PW'(1);
        dp_q  <= dp_q + PW'(1);
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // outputs from flip-flops
  logic busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE) || (wr_ok && is_ctrl && cond);
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign error_flag   = err_q;
  assign greater_flag = gt_q;
  assign equal_flag   = eq_q;
  assign less_flag    = lt_q;
  assign busy         = busy_q;
endmodule

//--- hw/bdm_pkg.sv
// Overview of operation
// - condition false: no destination or flag change
// - bit move: selector low/high digits pick bits
// - bad bcd or bit over 15 sets error
// - nibble move copies one to four digits
// - digits land consecutively, wrapping to digit 0
// - nibble selector digit 0, 1 or 2 above 3 sets error
// - transfer: low digits start bits, high count
// - transfer count up to 255 bits
// - past bit 15 continue at next word
// - transfer bits outside one area sets error
// - bad indirect pointer sets error
// - compare result goes to three status bits
// - exactly one of greater/equal/less set
// - table compare sets bit n on match
// - table past area end sets error
package bdm_pkg;

  localparam int ADDR_W = 12;
  localparam int WORD_W = 16;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SRC  = 12'h004;
  localparam logic [11:0] OFS_SEL  = 12'h008;
  localparam logic [11:0] OFS_DST  = 12'h00c;
  localparam logic [11:0] OFS_ADDR = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] MEM_BASE = 12'h100;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_COND   = 3;
  localparam int CTRL_IND    = 4;
  localparam int CTRL_W      = 5;

  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR  = 1;
  localparam int STAT_GT   = 2;
  localparam int STAT_EQ   = 3;
  localparam int STAT_LT   = 4;

  // reset values
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  localparam int TABLE_LEN = 16;
  localparam int BIT_MAX   = 15;
  localparam int DIG_MAX   = 3;
  localparam int BCD_MAX   = 9;

  typedef enum logic [2:0] {
    OP_BIT  = 3'h0,
    OP_NIB  = 3'h1,
    OP_XFR  = 3'h2,
    OP_CMP  = 3'h3,
    OP_TBL  = 3'h4
  } bdm_op_type;

endpackage

//--- hw/bdm_word_if.sv
interface bdm_word_if;
  import bdm_pkg::*;

  bdm_op_type  op;
  logic [15:0] src;
  logic [15:0] sel;
  logic [15:0] dst;
  logic [15:0] res;
  logic        err;
  logic        gt;
  logic        eq;
  logic        lt;

  modport host (output op, src, sel, dst, input res, err, gt, eq, lt);
  modport core (input op, src, sel, dst, output res, err, gt, eq, lt);
endinterface

//--- hw/bdm_bcd_word.sv
module bdm_bcd_word
  import bdm_pkg::*;
(
  // four bcd digits in
  input  wire logic [bdm_pkg::WORD_W-1:0] bcd,
  // binary value out
  output      logic [13:0]                bin,
  output      logic                       valid
);
  import bdm_pkg::*;

  logic [3:0] d0, d1, d2, d3;

  assign d0 = bcd[3:0];
  assign d1 = bcd[7:4];
  assign d2 = bcd[11:8];
  assign d3 = bcd[15:12];

  assign valid = (d0 <= 4'(BCD_MAX)) && (d1 <= 4'(BCD_MAX)) &&
                 (d2 <= 4'(BCD_MAX)) && (d3 <= 4'(BCD_MAX));
  assign bin = 14'(d3) * 14'd1000 + 14'(d2) * 14'd100 +
               14'(d1) * 14'd10 + 14'(d0);
endmodule

//--- hw/bdm_word_ops.sv
module bdm_word_ops
  import bdm_pkg::*;
(
  // operands and results
  bdm_word_if.core w
);
  import bdm_pkg::*;

  logic [3:0]  d0, d1, d2, d3;
  logic        bcd_ok;
  logic [6:0]  lo_pos, hi_pos;
  logic        bit_err, nib_err;
  logic [15:0] res_bit, res_nib;

  assign d0 = w.sel[3:0];
  assign d1 = w.sel[7:4];
  assign d2 = w.sel[11:8];
  assign d3 = w.sel[15:12];

  // single-bit move
  assign bcd_ok = (d0 <= 4'(BCD_MAX)) && (d1 <= 4'(BCD_MAX)) &&
                  (d2 <= 4'(BCD_MAX)) && (d3 <= 4'(BCD_MAX));
  assign lo_pos = 7'(d1) * 7'd10 + 7'(d0);
  assign hi_pos = 7'(d3) * 7'd10 + 7'(d2);
  assign bit_err = !bcd_ok || (lo_pos > 7'(BIT_MAX)) ||
                   (hi_pos > 7'(BIT_MAX));

  always_comb begin
    res_bit = w.dst;
    res_bit[hi_pos[3:0]] = w.src[lo_pos[3:0]];
  end

  // nibble move; digit 3 of the selector is don't-care
  assign nib_err = (d0 > 4'(DIG_MAX)) || (d1 > 4'(DIG_MAX)) ||
                   (d2 > 4'(DIG_MAX));

  for (genvar j = 0; j < 4; j++) begin : g_nib
    logic [1:0] k;
    logic [1:0] sidx;
    logic       take;
    assign k    = 2'(j) - d2[1:0];
    assign take = k <= d1[1:0];
    assign sidx = d0[1:0] + k;
    assign res_nib[4*j +: 4] = take ? w.src[4*sidx +: 4] : w.dst[4*j +: 4];
  end

  assign w.res = (w.op == OP_NIB) ? res_nib : res_bit;
  assign w.err = (w.op == OP_BIT) ? bit_err :
                 (w.op == OP_NIB) ? nib_err : 1'b0;

  // one comparison each, so only one flag can be true
  assign w.gt = w.src > w.sel;
  assign w.eq = w.src == w.sel;
  assign w.lt = w.src < w.sel;
endmodule

//--- test/bdm_unit_checker.sv
module bdm_unit_checker
  import bdm_pkg::*;
#(
  parameter int DEPTH = 64
)(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // flags
  input wire logic        error_flag,
  input wire logic        greater_flag,
  input wire logic        equal_flag,
  input wire logic        less_flag,
  input wire logic        busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic       acc = psel && penable && !pready;
  wire logic       ctl = pready && !pslverr && pwrite && paddr == OFS_CTRL;
  wire logic [2:0] cmp = {greater_flag, equal_flag, less_flag};
  // gap between status and memory window
  wire logic       hole = paddr >= 12'h018 && paddr < MEM_BASE;
  a_setup_quiet: assert property (psel && !penable |=> !pready)
    else $error("ready in setup cycle");
  a_ready_second: assert property (acc |=> pready)
    else $error("access not two cycles");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_hole_refused: assert property (acc && hole |=> pslverr)
    else $error("unmapped access accepted");
  // a write landing mid-op would corrupt operands
  a_busy_refused: assert property (acc && pwrite && busy |=> pslverr)
    else $error("write while busy accepted");
  a_cond_idle: assert property (ctl && !pwdata[CTRL_COND] |=> !busy [*2])
    else $error("op ran with condition false");
  a_short_op: assert property (ctl && pwdata[CTRL_COND]
    && pwdata[2:0] != OP_XFR |=> busy ##1 !busy)
    else $error("single op length wrong");
  a_flags_hold: assert property (!busy |=> $stable({error_flag, cmp}))
    else $error("flags moved while idle");
  a_one_result: assert property (|cmp |-> $onehot(cmp))
    else $error("compare flags not one hot");
  c_transfer: cover property (ctl && pwdata[2:0] == OP_XFR);
  c_busy_write: cover property (acc && pwrite && busy);
  c_greater: cover property (greater_flag);
  c_less: cover property (less_flag);
endmodule

bind bdm_unit bdm_unit_checker #(.DEPTH(DEPTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .error_flag(error_flag),
  .greater_flag(greater_flag), .equal_flag(equal_flag),
  .less_flag(less_flag), .busy(busy));

//--- test/bdm_apb_master.sv
module bdm_apb_master (
  // clock
  input  wire logic        pclk,
  // request
  output      logic        psel,
  output      logic        penable,
  output      logic        pwrite,
  output      logic [11:0] paddr,
  output      logic [31:0] pwdata,
  // answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hung;
  initial begin
    hung = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic se);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung = pready !== 1'b1;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- test/bit_digit_move_compare_unit_tb.sv
module bit_digit_move_compare_unit_tb;
  import bdm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int D = 64;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        error_flag, greater_flag, equal_flag, less_flag, busy;
  logic        me, mg, mq, ml;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] mem [D];
  logic [15:0] md;
  int          errors, checked;
  logic [15:0] bs [6] = '{16'h1500, 16'h0015, 16'h1600, 16'h0016,
                          16'h000a, 16'h0a00};
  logic [15:0] xs [6] = '{16'h05ed, 16'hff00, 16'h0000, 16'hff01,
                          16'hff02, 16'h02f0};
  logic [31:0] xa [6] = '{32'h001e0002, 32'h00280003, 32'h00050001,
                          32'h00000030, 32'h00000030, 32'h003f0001};
  logic [31:0] cv [5] = '{32'h00050004, 32'h00040004, 32'h00040005,
                          32'hffff0000, 32'h0000ffff};
  bdm_unit #(.DEPTH(D)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .error_flag(error_flag), .greater_flag(greater_flag),
    .equal_flag(equal_flag), .less_flag(less_flag), .busy(busy));
  bdm_apb_master m (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    m.xfer(w, a, d, r, e);
    if (m.hung) begin
      errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    chk("wrerr", 32'(e), 32'h0);
  endtask
  function automatic logic ok(input logic [15:0] v);
    return v[3:0] < 10 && v[7:4] < 10 && v[11:8] < 10 && v[15:12] < 10;
  endfunction
  task automatic mdl(input int op, c, ind, input logic [15:0] s, l,
                     input logic [31:0] a);
    int sb, db, n, bad, p;
    if (c == 0) return;
    p = a[15:12] * 1000 + a[11:8] * 100 + a[7:4] * 10 + a[3:0];
    bad = ind && (!ok(a[15:0]) || p >= D);
    if (ind == 0) p = a[15:0];
    case (op)
      0: begin
        sb = l[7:4] * 10 + l[3:0];
        db = l[15:12] * 10 + l[11:8];
        bad |= !ok(l) || sb > 15 || db > 15;
        if (bad == 0) md[db] = s[sb];
      end
      1: begin
        bad |= l[3:0] > 3 || l[7:4] > 3 || l[11:8] > 3;
        for (n = 0; n <= l[7:4] && bad == 0; n++)
          md[(l[11:8] + n) % 4 * 4 +: 4] = s[(l[3:0] + n) % 4 * 4 +: 4];
      end
      2: begin
        sb = p * 16 + l[3:0];
        db = a[31:16] * 16 + l[7:4];
        n = l[15:8];
        bad |= n != 0 && (sb + n > D * 16 || db + n > D * 16);
        for (int k = 0; k < n && bad == 0; k++)
          mem[(db+k)/16][(db+k)%16] = mem[(sb+k)/16][(sb+k)%16];
      end
      3: if (bad == 0) {mg, mq, ml} = {s > l, s == l, s < l};
      4: begin
        bad |= p + 15 >= D;
        for (int k = 0; k < 16 && bad == 0; k++)
          md[k] = s == mem[p + k];
      end
      default: bad = 1;
    endcase
    me = bad;
  endtask
  task automatic run(input int op, c, ind, input logic [15:0] s, l, d,
                     input logic [31:0] a);
    int n;
    md = d;
    wr(OFS_SRC, 32'(s));
    wr(OFS_SEL, 32'(l));
    wr(OFS_DST, 32'(d));
    wr(OFS_ADDR, a);
    mdl(op, c, ind, s, l, a);
    wr(OFS_CTRL, 32'({ind[0], c[0], op[2:0]}));
    if (op == 2 && c != 0 && !me && l[15:8] > 8) begin
      bus(1'b1, OFS_SRC, 32'h0);
      chk("busywr", 32'(e), 32'h1);
      chk("busyout", 32'(busy), 32'h1);
    end
    n = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0);
      n++;
    end while (r[STAT_BUSY] === 1'b1 && n < 400);
    chk("busy", 32'(r[STAT_BUSY]), 32'h0);
    if (r[STAT_BUSY] !== 1'b0)
      summarize();
    chk("stat", r, 32'({ml, mq, mg, me, 1'b0}));
    chk("flags", 32'({error_flag, greater_flag, equal_flag, less_flag}),
        32'({me, mg, mq, ml}));
    bus(1'b0, OFS_DST, 32'h0);
    chk("dst", r, 32'(md));
    for (int i = 0; i < D && op == 2; i++) begin
      bus(1'b0, MEM_BASE + 12'(4 * i), 32'h0);
      chk("mem", r, 32'(mem[i]));
    end
  endtask
  initial begin
    int sb, db;
    errors = 0;
    checked = 0;
    presetn = 1'b0;
    {me, mg, mq, ml} = 4'h0;
    void'($urandom(64011));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, OFS_STAT, 32'h0);
    chk("stat0", r, 32'h0);
    bus(1'b0, 12'h018, 32'h0);
    chk("hole", {r[30:0], e}, 32'h1);
    bus(1'b1, OFS_STAT, 32'h1f);
    chk("rostat", 32'(e), 32'h1);
    for (int i = 0; i < D; i++) begin
      mem[i] = 16'($urandom);
      wr(MEM_BASE + 12'(4 * i), 32'(mem[i]));
    end
    $display("test map done");
    for (int k = 0; k < 6; k++)
      run(0, 1, 0, 16'($urandom), bs[k], 16'($urandom), 0);
    repeat (6) begin
      sb = $urandom % 16;
      db = $urandom % 16;
      run(0, 1, 0, 16'($urandom), 16'({4'(db / 10), 4'(db % 10),
          4'(sb / 10), 4'(sb % 10)}), 16'($urandom), 0);
    end
    run(0, 0, 0, 16'hffff, 16'h0000, 16'h0000, 0);
    $display("test bit move done");
    repeat (6) run(1, 1, 0, 16'($urandom), 16'($urandom) & 16'hf333,
                   16'($urandom), 0);
    for (int k = 0; k < 3; k++)
      run(1, 1, 0, 16'($urandom), 16'h0004 << (4 * k), 16'h1234, 0);
    $display("test nibble move done");
    for (int k = 0; k < 6; k++)
      run(2, 1, 0, 0, xs[k], 0, xa[k]);
    repeat (2) run(2, 1, 0, 0, 16'($urandom), 0,
                   {16'(32 + $urandom % 16), 16'($urandom % 16)});
    $display("test transfer done");
    for (int k = 0; k < 5; k++)
      run(3, 1, 0, cv[k][31:16], cv[k][15:0], 0, 0);
    repeat (3) run(3, 1, 0, 16'($urandom), 16'($urandom), 0, 0);
    run(3, 0, 0, 16'h0001, 16'h0002, 0, 0);
    for (int k = 5; k < 8; k++)
      run(k, 1, 0, 0, 0, 16'h00ff, 0);
    $display("test compare done");
    for (int k = 0; k < 16; k += 3) begin
      mem[10 + k] = 16'h0210;
      wr(MEM_BASE + 12'(4 * (10 + k)), 32'h0210);
    end
    run(4, 1, 0, 16'h0210, 0, 16'($urandom), 10);
    run(4, 1, 0, mem[48], 0, 0, 48);
    run(4, 1, 0, 0, 0, 16'h5a5a, 49);
    for (int k = 0; k < 5; k++)
      run(k, 1, 1, 0, 0, 16'h0f0f, k % 2 ? 32'h1a : 32'h64);
    run(4, 1, 1, 16'h0210, 0, 16'h0000, 32'h10);
    run(2, 1, 1, 0, 16'h0310, 0, 32'h00200005);
    $display("test table and pointer done");
    summarize();
  end
endmodule
